// ==== design/ledi2c_pkg.sv ====
package ledi2c_pkg;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 4;
    localparam int SYNC_W = 4;

    // Target address layout
    localparam logic [2:0] ADDR_TOP = 3'h6;

    // Register offsets
    localparam logic [7:0] OFS_PRODUCT_IDENTITY = 8'hFC;
    localparam logic [7:0] OFS_PAGE_SELECT = 8'hFD;
    localparam logic [7:0] OFS_PAGE_SELECT_UNLOCK = 8'hFE;

    // Reset values and codes
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] PAGE_SELECT_UNLOCK_RESET = 8'h00;
    localparam logic [7:0] PAGE_SELECT_UNLOCK_KEY = 8'hC5;
    localparam logic [7:0] PWM_PAGE = 8'h00;
    localparam logic [7:0] SCALING_FUNCTION_PAGE = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // Strap codes
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_SCL = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    localparam logic [1:0] STRAP_VCC = 2'h3;

    // Bit counter marks within a nine-clock byte frame
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;

    // Positions in the pin synchroniser vector
    localparam int SYN_SDA = 0;
    localparam int SYN_SCL = 1;
    localparam int SYN_LO = 2;
    localparam int SYN_HI = 3;

    // Timing: shortest controller clock period against the system clock
    localparam int SYS_PERIOD_NS = 20;
    localparam int SCL_MIN_PERIOD_NS = 1000;
    localparam int SCL_MIN_PERIOD_CYC = SCL_MIN_PERIOD_NS / SYS_PERIOD_NS;
    localparam int SCL_MIN_PERIOD_NEED = 8;

    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_REG = 2'h1,
        K_DATA = 2'h2
    } ledi2c_kind_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_MACK = 5'h10
    } ledi2c_state_t;
endpackage : ledi2c_pkg

// ==== design/ledi2c_strap_decode.sv ====
`timescale 1ns/1ps
module ledi2c_strap_decode (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_pin,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic [1:0] o_code
);
    import ledi2c_pkg::*;

    logic seen_high;
    logic seen_low;
    logic differ_scl;
    logic differ_sda;

    // Idle bus looks like supply; SCL/SDA ties only show once the bus moves
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            seen_high <= 1'b0;
            seen_low <= 1'b0;
            differ_scl <= 1'b0;
            differ_sda <= 1'b0;
        end else begin
            seen_high <= seen_high | i_pin;
            seen_low <= seen_low | ~i_pin;
            differ_scl <= differ_scl | (i_pin ^ i_scl);
            differ_sda <= differ_sda | (i_pin ^ i_sda);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_code <= STRAP_GND;
        end else if (!seen_high) begin
            o_code <= STRAP_GND;
        end else if (!seen_low) begin
            o_code <= STRAP_VCC;
        end else if (!differ_scl) begin
            o_code <= STRAP_SCL;
        end else if (!differ_sda) begin
            o_code <= STRAP_SDA;
        end else begin
            // Only a grounded pin lands here: the synchroniser resets high
            o_code <= STRAP_GND;
        end
    end
endmodule : ledi2c_strap_decode

// ==== design/ledi2c_target.sv ====
// What this block does
// - Seven-bit address, direction bit last
// - Address 110, high strap, low strap
// - Strap to GND/VCC/SCL/SDA gives 00/11/01/10
// - Data sampled while clock high; idle high
// - SDA fall/rise with SCL high: start/stop
// - Acknowledge address byte only on match
// - Register address byte follows, acknowledged
// - Each write data byte acknowledged
// - Pointer advances at each data acknowledge
// - Read: write pointer, repeated start, read
// - Page 0 PWM, page 1 scaling, rest reserved
// - Writes go into the selected page
// - Page select locked at reset, page zero
// - Key C5 allows one page change, relocks
// - Unlock register readable, writable, resets zero
`timescale 1ns/1ps
module ledi2c_target #(
    parameter logic [2:0] ID_PREFIX = 3'h2 // Arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_scl_link,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_high_address_strap_pin,
    input wire logic i_low_address_strap_pin,
    output logic [ledi2c_pkg::BYTE_W-1:0] o_page,
    output logic [ledi2c_pkg::BYTE_W-1:0] o_rd_addr,
    output logic [ledi2c_pkg::BYTE_W-1:0] o_wr_addr,
    output logic [ledi2c_pkg::BYTE_W-1:0] o_wr_data,
    output logic o_pwm_wr_en,
    output logic o_scale_wr_en,
    input wire logic [ledi2c_pkg::BYTE_W-1:0] i_pwm_rd_data,
    input wire logic [ledi2c_pkg::BYTE_W-1:0] i_scale_rd_data
);
    import ledi2c_pkg::*;

    if (SCL_MIN_PERIOD_CYC < SCL_MIN_PERIOD_NEED) begin : g_rate_check
        $error("system clock too slow for the serial clock rate");
    end

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic [1:0] hi_code;
    logic [1:0] lo_code;
    logic [7:0] link_byte;
    ledi2c_state_t st;
    ledi2c_kind_t kind;
    logic [CNT_W-1:0] cnt;
    logic rw;
    logic mack_ok;
    logic [7:0] tx;
    logic [7:0] unlock;
    logic [7:0] id_value;
    logic [7:0] own_addr;
    logic [7:0] rd_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic data_done;
    logic addr_hit;

    function automatic logic page_valid(input logic [7:0] pg);
        page_valid = (pg == PWM_PAGE) || (pg == SCALING_FUNCTION_PAGE);
    endfunction : page_valid

    function automatic logic [7:0] rd_mux(input logic [7:0] addr, input logic [7:0] pg,
                                          input logic [7:0] pwm, input logic [7:0] scale,
                                          input logic [7:0] idv, input logic [7:0] key);
        if (addr == OFS_PRODUCT_IDENTITY) begin
            rd_mux = idv;
        end else if (addr == OFS_PAGE_SELECT_UNLOCK) begin
            rd_mux = key;
        end else if (addr == OFS_PAGE_SELECT || !page_valid(pg)) begin
            rd_mux = 8'h00;
        end else if (pg == PWM_PAGE) begin
            rd_mux = pwm;
        end else begin
            rd_mux = scale;
        end
    endfunction : rd_mux

    // Pins cross in through two flops; a third copy feeds the edge detectors
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1 <= '1;
            sync2 <= '1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {i_high_address_strap_pin, i_low_address_strap_pin, i_scl, i_sda_in};
            sync2 <= sync1;
            scl_d <= sync2[SYN_SCL];
            sda_d <= sync2[SYN_SDA];
        end
    end

    assign scl_s = sync2[SYN_SCL];
    assign sda_s = sync2[SYN_SDA];

    ledi2c_strap_decode u_hi_strap (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pin(sync2[SYN_HI]),
        .i_scl(scl_s),
        .i_sda(sda_s),
        .o_code(hi_code)
    );

    ledi2c_strap_decode u_lo_strap (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pin(sync2[SYN_LO]),
        .i_scl(scl_s),
        .i_sda(sda_s),
        .o_code(lo_code)
    );

    // Link side: bits shift in on the controller's own rising clock
    always_ff @(posedge i_scl_link or negedge i_resetn) begin
        if (!i_resetn) begin
            link_byte <= 8'h00;
        end else begin
            link_byte <= {link_byte[6:0], i_sda_in};
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
    // Link byte is stable from the eighth rise until the next one
    assign byte_done = (st == ST_RECV) && scl_fall && (cnt == BIT_LAST);
    assign data_done = byte_done && (kind == K_DATA);
    assign own_addr = {ADDR_TOP, hi_code, lo_code, 1'b0};
    assign addr_hit = (link_byte[7:1] == own_addr[7:1]);
    assign id_value = {ID_PREFIX, hi_code, lo_code, 1'b0};
    assign rd_byte = rd_mux(o_rd_addr, o_page, i_pwm_rd_data, i_scale_rd_data, id_value, unlock);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
        end
    end

    // Byte framing, acknowledge and read shifting
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= ST_IDLE;
            kind <= K_ADDR;
            cnt <= CNT_RESET;
            rw <= 1'b0;
            mack_ok <= 1'b0;
            tx <= 8'h00;
            o_sda_oe <= 1'b0;
        end else if (start_det) begin
            st <= ST_RECV;
            kind <= K_ADDR;
            cnt <= CNT_RESET;
            o_sda_oe <= 1'b0;
        end else if (stop_det) begin
            st <= ST_IDLE;
            cnt <= CNT_RESET;
            o_sda_oe <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (byte_done) begin
                        if (kind != K_ADDR || addr_hit) begin
                            st <= ST_ACK;
                            o_sda_oe <= 1'b1;
                            if (kind == K_ADDR) begin
                                rw <= link_byte[0];
                            end
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall && cnt == BIT_ACK) begin
                        cnt <= CNT_RESET;
                        if (kind == K_ADDR && rw) begin
                            st <= ST_SEND;
                            o_sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b0};
                        end else begin
                            st <= ST_RECV;
                            o_sda_oe <= 1'b0;
                            kind <= (kind == K_ADDR) ? K_REG : K_DATA;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall && cnt == BIT_LAST) begin
                        st <= ST_MACK;
                        o_sda_oe <= 1'b0;
                    end else if (scl_fall && cnt != CNT_RESET) begin
                        o_sda_oe <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                        mack_ok <= ~sda_s;
                    end else if (scl_fall && cnt == BIT_ACK) begin
                        cnt <= CNT_RESET;
                        if (mack_ok) begin
                            st <= ST_SEND;
                            o_sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b0};
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st <= ST_IDLE;
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Register pointer
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_addr <= PTR_RESET;
        end else if (byte_done && kind == K_REG) begin
            o_rd_addr <= link_byte;
        end else if (data_done) begin
            o_rd_addr <= o_rd_addr + 8'h01;
        end else if (st == ST_MACK && scl_rise && !sda_s) begin
            o_rd_addr <= o_rd_addr + 8'h01;
        end
    end

    // Local registers; page select needs the key each time
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_page <= PAGE_SELECT_RESET;
            unlock <= PAGE_SELECT_UNLOCK_RESET;
        end else if (data_done) begin
            if (o_rd_addr == OFS_PAGE_SELECT_UNLOCK) begin
                unlock <= link_byte;
            end else if (o_rd_addr == OFS_PAGE_SELECT && unlock == PAGE_SELECT_UNLOCK_KEY) begin
                o_page <= link_byte;
                unlock <= PAGE_SELECT_UNLOCK_RESET;
            end
        end
    end

    // Paged writes; reserved pages and local offsets raise no strobe
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wr_addr <= PTR_RESET;
            o_wr_data <= 8'h00;
            o_pwm_wr_en <= 1'b0;
            o_scale_wr_en <= 1'b0;
        end else begin
            o_pwm_wr_en <= 1'b0;
            o_scale_wr_en <= 1'b0;
            if (data_done && o_rd_addr < OFS_PRODUCT_IDENTITY) begin
                o_wr_addr <= o_rd_addr;
                o_wr_data <= link_byte;
                o_pwm_wr_en <= (o_page == PWM_PAGE);
                o_scale_wr_en <= (o_page == SCALING_FUNCTION_PAGE);
            end
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    sequence seq_addr_done;
        byte_done && kind == K_ADDR;
    endsequence

    sequence seq_page_key_write;
        data_done && o_rd_addr == OFS_PAGE_SELECT && unlock == PAGE_SELECT_UNLOCK_KEY;
    endsequence

    chk_addr_ack_hit: assert property (seq_addr_done ##0 addr_hit |=> o_sda_oe && st == ST_ACK)
        else $error("matching address not acknowledged");
    chk_addr_miss_quiet: assert property (seq_addr_done ##0 !addr_hit |=> !o_sda_oe [*2])
        else $error("foreign address acknowledged");
    chk_ptr_advance: assert property (data_done |=> o_rd_addr == $past(o_rd_addr) + 8'h01)
        else $error("pointer did not advance after data byte");
    chk_unlock_once: assert property (seq_page_key_write |=> o_page == $past(link_byte) && unlock == 8'h00)
        else $error("keyed page write did not take or relock");
    chk_page_locked: assert property (data_done && unlock != PAGE_SELECT_UNLOCK_KEY |=> $stable(o_page))
        else $error("locked page select changed");
    chk_unlock_write: assert property (data_done && o_rd_addr == OFS_PAGE_SELECT_UNLOCK |=> unlock == $past(link_byte))
        else $error("unlock register write lost");
    chk_page_route: assert property (data_done && o_rd_addr < OFS_PRODUCT_IDENTITY && o_page == SCALING_FUNCTION_PAGE |=> o_scale_wr_en && !o_pwm_wr_en)
        else $error("write not routed to selected page");
    chk_start_frame: assert property (start_det |=> st == ST_RECV && kind == K_ADDR && cnt == CNT_RESET)
        else $error("start did not open an address frame");
    chk_stop_release: assert property (stop_det |=> st == ST_IDLE ##1 !o_sda_oe)
        else $error("stop did not end the transfer");
    chk_idle_release: assert property (st == ST_IDLE [*2] |-> !o_sda_oe)
        else $error("data line held while idle");
    chk_id_fixed: assert property (o_rd_addr == OFS_PRODUCT_IDENTITY |-> rd_byte[0] == 1'b0 && rd_byte[4:1] == {hi_code, lo_code})
        else $error("identity value does not follow straps");
endmodule : ledi2c_target

// ==== dv/ledi2c_ctl_model.sv ====
`timescale 1ns/1ps
module ledi2c_ctl_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    logic clk_link;

    // Own 80 ns base, phase unrelated to the system clock
    initial begin
        clk_link = 1'b0;
        #7;
        forever #40 clk_link = ~clk_link;
    end

    // Clock parked high, data released while idle
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    // Seven ticks a half period; 15-tick bit, 1.2 us, under 1 MHz
    task automatic half();
        repeat (7) @(posedge clk_link);
    endtask : half

    // Also a repeated start when entered with clock low
    task automatic start();
        @(posedge clk_link);
        o_sda_pull <= 1'b0;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_pull <= 1'b1;
        half();
        o_scl <= 1'b0;
    endtask : start

    // Data moves a tick after the clock fall, never with it
    task automatic bit_io(input logic b, output logic s);
        @(posedge clk_link);
        o_sda_pull <= ~b;
        half();
        o_scl <= 1'b1;
        half();
        s = i_sda;
        o_scl <= 1'b0;
    endtask : bit_io

    // MSB first, then release for the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : send_byte

    // Acknowledge every byte but the last
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask : recv_byte

    task automatic stop();
        @(posedge clk_link);
        o_sda_pull <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_pull <= 1'b0;
        half();
    endtask : stop

    // Abandon when the address is not acknowledged
    task automatic addr_phase(input logic [6:0] a, input logic rw, output logic ack);
        start();
        send_byte({a, rw}, ack);
        if (!ack) begin
            stop();
        end
    endtask : addr_phase
endmodule : ledi2c_ctl_model

// ==== dv/tb_led_matrix_i2c_page_access.sv ====
`timescale 1ns/1ps
module tb_led_matrix_i2c_page_access;
    import ledi2c_pkg::*;
    localparam logic [2:0] ID_P = 3'h3; // Arbitrary value
    logic clk_sys, resetn, scl, sda_pull, sda_out, sda_oe, hi_pin, lo_pin;
    logic pwm_en, scale_en;
    logic [1:0] hi_sel, lo_sel;
    logic [7:0] page, rd_addr, wr_addr, wr_data;
    logic [7:0] pwm_mem [256];
    logic [7:0] scale_mem [256];
    int n_pwm, n_scale, n_errors, checks;
    // Wired-AND with pull-up
    wire sda = ~(sda_pull | (sda_oe & ~sda_out));
    wire [6:0] dev = {ADDR_TOP, hi_sel, lo_sel};
    assign hi_pin = (hi_sel == STRAP_GND) ? 1'b0 : (hi_sel == STRAP_SCL) ? scl :
        (hi_sel == STRAP_SDA) ? sda : 1'b1;
    assign lo_pin = (lo_sel == STRAP_GND) ? 1'b0 : (lo_sel == STRAP_SCL) ? scl :
        (lo_sel == STRAP_SDA) ? sda : 1'b1;

    ledi2c_ctl_model u_ctl (.i_sda(sda), .o_scl(scl), .o_sda_pull(sda_pull));

    ledi2c_target #(.ID_PREFIX(ID_P)) u_dut (
        .i_clk_sys(clk_sys), .i_resetn(resetn), .i_scl_link(scl), .i_scl(scl),
        .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_high_address_strap_pin(hi_pin), .i_low_address_strap_pin(lo_pin),
        .o_page(page), .o_rd_addr(rd_addr), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_pwm_wr_en(pwm_en), .o_scale_wr_en(scale_en),
        .i_pwm_rd_data(pwm_mem[rd_addr]), .i_scale_rd_data(scale_mem[rd_addr])
    );

    // Page storage stand-in; strobe counts expose stray writes
    always @(posedge clk_sys) begin
        if (pwm_en === 1'b1) begin
            pwm_mem[wr_addr] <= wr_data;
            n_pwm <= n_pwm + 1;
        end
        if (scale_en === 1'b1) begin
            scale_mem[wr_addr] <= wr_data;
            n_scale <= n_scale + 1;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic do_reset(input logic [1:0] h, input logic [1:0] l);
        @(posedge clk_sys);
        resetn <= 1'b0;
        hi_sel <= h;
        lo_sel <= l;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : do_reset

    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic a0, a1, a2;
        u_ctl.addr_phase(dev, 1'b0, a0);
        u_ctl.send_byte(r, a1);
        u_ctl.send_byte(d, a2);
        u_ctl.stop();
        chk({5'h0, a0, a1, a2}, 8'h07);
    endtask : wr

    task automatic rd(input logic [7:0] r, input logic two, output logic [7:0] d0,
        output logic [7:0] d1);
        logic a0, a1, a2;
        d1 = 8'h00;
        u_ctl.addr_phase(dev, 1'b0, a0);
        u_ctl.send_byte(r, a1);
        u_ctl.addr_phase(dev, 1'b1, a2);
        u_ctl.recv_byte(~two, d0);
        if (two) begin
            u_ctl.recv_byte(1'b1, d1);
        end
        u_ctl.stop();
        chk({5'h0, a0, a1, a2}, 8'h07);
    endtask : rd

    task automatic sel_page(input logic [7:0] p);
        wr(OFS_PAGE_SELECT_UNLOCK, PAGE_SELECT_UNLOCK_KEY);
        wr(OFS_PAGE_SELECT, p);
    endtask : sel_page

    task automatic t_reset();
        logic [7:0] d0, d1;
        chk(page, 8'h00);
        chk({7'h0, sda_oe}, 8'h00);
        rd(OFS_PAGE_SELECT_UNLOCK, 1'b0, d0, d1);
        chk(d0, 8'h00);
    endtask : t_reset

    task automatic t_addr();
        logic a;
        u_ctl.addr_phase(dev ^ 7'h08, 1'b0, a);
        chk({7'h0, a}, 8'h00);
        u_ctl.addr_phase(dev ^ 7'h41, 1'b1, a);
        chk({7'h0, a}, 8'h00);
    endtask : t_addr

    task automatic t_lock();
        logic [7:0] d0, d1;
        wr(OFS_PAGE_SELECT, 8'h01);
        chk(page, 8'h00);
        wr(OFS_PAGE_SELECT_UNLOCK, 8'hC5);
        rd(OFS_PAGE_SELECT_UNLOCK, 1'b0, d0, d1);
        chk(d0, 8'hC5);
        wr(OFS_PAGE_SELECT, 8'h01);
        chk(page, 8'h01);
        rd(OFS_PAGE_SELECT_UNLOCK, 1'b0, d0, d1);
        chk(d0, 8'h00);
        wr(OFS_PAGE_SELECT, 8'h00);
        chk(page, 8'h01);
    endtask : t_lock

    // Three-byte burst into the scaling page, then read back
    task automatic t_burst();
        logic a;
        logic [7:0] d0, d1;
        int np;
        np = n_pwm;
        u_ctl.addr_phase(dev, 1'b0, a);
        u_ctl.send_byte(8'h10, a);
        for (int i = 0; i < 3; i++) begin
            u_ctl.send_byte(8'hA1 + 8'(i * 17), a);
            chk({7'h0, a}, 8'h01);
        end
        u_ctl.stop();
        chk(scale_mem[8'h10], 8'hA1);
        chk(scale_mem[8'h11], 8'hB2);
        chk(scale_mem[8'h12], 8'hC3);
        chk(8'(n_pwm - np), 8'h00);
        rd(8'h11, 1'b1, d0, d1);
        chk(d0, 8'hB2);
        chk(d1, 8'hC3);
        sel_page(8'h00);
        wr(8'h20, 8'h5A);
        chk(pwm_mem[8'h20], 8'h5A);
    endtask : t_burst

    task automatic t_reserved();
        logic [7:0] d0, d1;
        int ns;
        sel_page(8'h02);
        chk(page, 8'h02);
        ns = n_pwm + n_scale;
        wr(8'h12, 8'h77);
        chk(8'(n_pwm + n_scale - ns), 8'h00);
        rd(8'h12, 1'b0, d0, d1);
        chk(d0, 8'h00);
    endtask : t_reserved

    // Every strap code on both pins, then a write to the identity
    task automatic t_id();
        logic [7:0] d0, d1;
        for (int i = 0; i < 4; i++) begin
            do_reset(2'(i), 2'(3 - i));
            rd(OFS_PRODUCT_IDENTITY, 1'b0, d0, d1);
            chk(d0, {ID_P, 2'(i), 2'(3 - i), 1'b0});
        end
        wr(OFS_PRODUCT_IDENTITY, 8'hFF);
        rd(OFS_PRODUCT_IDENTITY, 1'b0, d0, d1);
        chk(d0, {ID_P, 4'hC, 1'b0});
    endtask : t_id

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        resetn = 1'b0;
        hi_sel = STRAP_SCL;
        lo_sel = STRAP_SDA;
        n_pwm = 0;
        n_scale = 0;
        n_errors = 0;
        checks = 0;
        for (int i = 0; i < 256; i++) begin
            pwm_mem[i] = 8'h00;
            scale_mem[i] = 8'h00;
        end
        do_reset(STRAP_SCL, STRAP_SDA);
        t_reset();
        t_addr();
        t_lock();
        t_burst();
        t_reserved();
        t_id();
        print_verdict();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end
endmodule : tb_led_matrix_i2c_page_access
